// file: nand_flash_model.sv
// Behavioural x8 NAND flash device answering the host controller
`timescale 1ns/1ps
module nand_flash_model
#(
    parameter int BUSY_NS = 25000,
    parameter int TREA_NS = 16,
    parameter int TWB_NS  = 40
)
(
    // Host side pins
    input  wire logic       ce_n_i,
    input  wire logic       cle_i,
    input  wire logic       ale_i,
    input  wire logic       we_n_i,
    input  wire logic       re_n_i,
    input  wire logic       wp_n_i,
    input  wire logic       protect_i,
    input  wire logic [7:0] io_i,
    // Device outputs
    output logic [7:0]      io_o,
    output logic            rb_low_o,
    output logic            standby_o
);
    logic [7:0]  addr_q [4];
    logic [15:0] cmd_hist = 16'hFFFF;
    logic [2:0]  n_addr   = 3'h0;
    logic [11:0] col      = 12'h000;
    logic        array_locked;
    int          n_conf   = 0;
    int          n_reads  = 0;
    int          n_viol   = 0;
    event        go_busy;
    initial
    begin
        io_o = 8'h00;
        rb_low_o = 1'b0;
        // Array lock is sampled once, set by protect_i high or wp_n_i low
        #1 array_locked = protect_i | ~wp_n_i;
    end
    assign standby_o = ce_n_i & ~rb_low_o;
    always @(posedge we_n_i)
    begin
        if (!ce_n_i && cle_i && ale_i)
            n_viol++;
        if (!ce_n_i && cle_i)
        begin
            if (io_i == 8'h00)
                n_addr = 3'h0;
            if (io_i == 8'h30)
            begin
                if (cmd_hist[7:0] != 8'h00 || n_addr != 3'h4)
                    n_viol++;
                n_conf++;
                col = {addr_q[1][3:0], addr_q[0]};
                -> go_busy;
            end
            cmd_hist = {cmd_hist[7:0], io_i};
        end
        else if (!ce_n_i && ale_i && n_addr < 3'h4)
        begin
            if (n_addr == 3'h1 && io_i[7:4] != 4'h0)
                n_viol++;
            addr_q[n_addr] = io_i;
            n_addr = n_addr + 3'h1;
        end
    end
    // Busy runs on regardless of chip enable
    always @(go_busy)
    begin
        #(TWB_NS);
        rb_low_o = 1'b1;
        #(BUSY_NS);
        rb_low_o = 1'b0;
    end
    always @(negedge re_n_i)
    begin
        if (!ce_n_i && !rb_low_o)
        begin
            if (!we_n_i)
                n_viol++;
            n_reads++;
            #(TREA_NS);
            io_o = col[7:0] ^ addr_q[2] ^ addr_q[3] ^ {4'h0, col[11:8]};
            col = col + 12'h001;
        end
    end
    always @(negedge we_n_i)
    begin
        if (!re_n_i)
            n_viol++;
    end
    // Released bus shows the inverse of the last byte
    always @(posedge re_n_i)
        #4 io_o = ~io_o;
endmodule : nand_flash_model

// file: nand_host_consts.svh
// Timing counts and command codes for the NAND host controller
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH
`define CLK_PERIOD_NS      4
`define T_STROBE_NS        20
`define T_STROBE_CYC       ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_ACCESS_NS        20
`define T_ACCESS_CYC       ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WB_NS            100
`define T_WB_CYC           ((`T_WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_READ_SETUP     8'h00
`define CMD_READ_CONFIRM   8'h30
`define PAGE_BYTES         12'h840
`define PAGES_PER_BLOCK    7'h40
`define ADDR_CYCLES        3'h4
`define COL_HI_MASK        8'h0F
`define CNT_W              8
`endif

// file: nand_host_ctrl.sv
// Host controller that runs a page read on an x8 NAND flash
`timescale 1ns/1ps
`include "nand_host_consts.svh"
module nand_host_ctrl
(
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // User request
    input  wire logic        START_I,
    input  wire logic [11:0] COL_I,
    input  wire logic [15:0] ROW_I,
    input  wire logic        WP_ENABLE_I,
    input  wire logic        PROTECT_I,
    output logic             BUSY_O,
    output logic             DONE_O,
    // Read data stream
    output logic             DATA_VALID_O,
    output logic [7:0]       DATA_O,
    input  wire logic        DATA_READY_I,
    // NAND pins
    output logic             CE_N_O,
    output logic             CLE_O,
    output logic             ALE_O,
    output logic             WE_N_O,
    output logic             READ_STROBE_N_O,
    output logic             WP_N_O,
    output logic             POWER_ON_PROTECT_O,
    output logic [7:0]       IO_BUS_O,
    output logic             IO_BUS_OE_O,
    input  wire logic [7:0]  IO_BUS_I,
    input  wire logic        RB_I
);
    nand_host_pkg::host_state_e state_q, state_d;
    nand_host_pkg::page_addr_s  addr_q;
    nand_host_pkg::ctrl_pins_s  pins_q, pins_d;
    logic [`CNT_W-1:0] tmr_q;
    logic [2:0]        acnt_q;
    logic [11:0]       bytes_q;
    logic [7:0]        io_q, io_d;
    logic              oe_q, oe_d;
    logic [2:0]        rb_sync_q;
    logic              rb_q;
    logic              done_q;
    logic              busy_q;
    logic              push_q;
    logic [7:0]        push_data_q;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic [7:0]        buf_out_data;

    // Ready/busy from the pin, filtered through three flops
    wire rb_agree = rb_sync_q[2] == rb_sync_q[1];
    wire rb_ready = rb_q;
    wire tmr_zero = tmr_q == '0;
    wire [7:0] addr_byte = (acnt_q == 3'h0) ? addr_q.col[7:0]
                         : (acnt_q == 3'h1) ? {4'h0, addr_q.col[11:8]} & `COL_HI_MASK
                         : (acnt_q == 3'h2) ? addr_q.row[7:0]
                         : addr_q.row[15:8];
    wire last_addr = acnt_q == `ADDR_CYCLES;
    wire last_byte = bytes_q == (`PAGE_BYTES - 12'h001);
    // A write cycle holds the strobe low for the first half of the timer
    wire strobe_phase = tmr_q >= `CNT_W'(`T_STROBE_CYC);

    nand_skid_buf u_buf
    (
        .clk_i       (CLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (push_q),
        .in_data_i   (push_data_q),
        .in_ready_o  (buf_in_ready),
        .out_valid_o (buf_out_valid),
        .out_data_o  (buf_out_data),
        .out_ready_i (DATA_READY_I)
    );

    always_comb
    begin
        state_d      = state_q;
        pins_d       = pins_q;
        io_d         = io_q;
        oe_d         = oe_q;
        pins_d.wp_n  = WP_ENABLE_I;
        pins_d.protect = PROTECT_I;
        unique case (state_q)
            nand_host_pkg::ST_IDLE:
            begin
                pins_d.ce_n = 1'b1;
                pins_d.cle  = 1'b0;
                pins_d.ale  = 1'b0;
                pins_d.we_n = 1'b1;
                pins_d.re_n = 1'b1;
                oe_d        = 1'b0;
                if (START_I && rb_ready)
                begin
                    state_d     = nand_host_pkg::ST_CMD;
                    pins_d.ce_n = 1'b0;
                    pins_d.cle  = 1'b1;
                    pins_d.we_n = 1'b0;
                    io_d        = `CMD_READ_SETUP;
                    oe_d        = 1'b1;
                end
            end
            nand_host_pkg::ST_CMD, nand_host_pkg::ST_ADDR, nand_host_pkg::ST_CONF:
            begin
                if (!strobe_phase)
                    pins_d.we_n = 1'b1;
                if (tmr_zero)
                begin
                    pins_d.we_n = 1'b0;
                    pins_d.cle  = 1'b0;
                    pins_d.ale  = 1'b1;
                    io_d        = addr_byte;
                    if (state_q == nand_host_pkg::ST_CMD)
                        state_d = nand_host_pkg::ST_ADDR;
                    else if (state_q == nand_host_pkg::ST_ADDR && !last_addr)
                        io_d = addr_byte;
                    else if (state_q == nand_host_pkg::ST_ADDR)
                    begin
                        state_d    = nand_host_pkg::ST_CONF;
                        pins_d.ale = 1'b0;
                        pins_d.cle = 1'b1;
                        io_d       = `CMD_READ_CONFIRM;
                    end
                    else
                    begin
                        state_d     = nand_host_pkg::ST_WAITB;
                        pins_d.we_n = 1'b1;
                        pins_d.ale  = 1'b0;
                        pins_d.cle  = 1'b0;
                        oe_d        = 1'b0;
                    end
                end
            end
            nand_host_pkg::ST_WAITB:
                if (tmr_zero)
                    state_d = nand_host_pkg::ST_BUSY;
            nand_host_pkg::ST_BUSY:
                if (rb_ready)
                    state_d = nand_host_pkg::ST_READ;
            nand_host_pkg::ST_READ:
            begin
                // strobe only when the timer has run out and the buffer has room
                if (tmr_zero && pins_q.re_n && buf_in_ready)
                    pins_d.re_n = 1'b0;
                else if (tmr_zero && !pins_q.re_n)
                begin
                    pins_d.re_n = 1'b1;
                    if (last_byte)
                        state_d = nand_host_pkg::ST_DONE;
                end
            end
            nand_host_pkg::ST_DONE:
            begin
                pins_d.ce_n = 1'b1;
                state_d     = nand_host_pkg::ST_IDLE;
            end
            default:
                state_d = nand_host_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_q     <= nand_host_pkg::ST_IDLE;
            pins_q      <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                             wp_n: 1'b0, protect: 1'b0};
            io_q        <= 8'h00;
            oe_q        <= 1'b0;
            rb_sync_q   <= 3'h7;
            rb_q        <= 1'b1;
            done_q      <= 1'b0;
            busy_q      <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            pins_q    <= pins_d;
            io_q      <= io_d;
            oe_q      <= oe_d;
            rb_sync_q <= {rb_sync_q[1:0], RB_I};
            if (rb_agree)
                rb_q <= rb_sync_q[2];
            done_q    <= state_q == nand_host_pkg::ST_DONE;
            busy_q    <= state_d != nand_host_pkg::ST_IDLE;
        end
    end

    // Bus cycle timer, address cycle counter and byte counter
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            tmr_q       <= '0;
            acnt_q      <= 3'h0;
            bytes_q     <= 12'h000;
            addr_q      <= '0;
            push_q      <= 1'b0;
            push_data_q <= 8'h00;
        end
        else
        begin
            push_q <= 1'b0;
            if (state_q == nand_host_pkg::ST_IDLE && state_d == nand_host_pkg::ST_CMD)
            begin
                addr_q  <= '{col: COL_I, row: ROW_I};
                acnt_q  <= 3'h0;
                bytes_q <= COL_I;
            end
            if (state_d != state_q && state_d == nand_host_pkg::ST_WAITB)
                tmr_q <= `CNT_W'(`T_WB_CYC);
            else if (state_d != state_q && state_d == nand_host_pkg::ST_READ)
                tmr_q <= '0;
            else if (pins_d.we_n == 1'b0 && pins_q.we_n == 1'b1)
                tmr_q <= `CNT_W'(2 * `T_STROBE_CYC - 1);
            else if (pins_d.re_n != pins_q.re_n)
                tmr_q <= `CNT_W'(`T_ACCESS_CYC);
            else if (!tmr_zero)
                tmr_q <= tmr_q - `CNT_W'(1);
            // Counts address bytes already put on the bus
            if ((state_q == nand_host_pkg::ST_CMD || state_q == nand_host_pkg::ST_ADDR) && tmr_zero)
                acnt_q <= acnt_q + 3'h1;
            // Capture once access delay has elapsed, just before strobe release
            if (state_q == nand_host_pkg::ST_READ && tmr_zero && !pins_q.re_n)
            begin
                push_q      <= 1'b1;
                push_data_q <= IO_BUS_I;
                bytes_q     <= bytes_q + 12'h001;
            end
        end
    end

    assign CE_N_O             = pins_q.ce_n;
    assign CLE_O              = pins_q.cle;
    assign ALE_O              = pins_q.ale;
    assign WE_N_O             = pins_q.we_n;
    assign READ_STROBE_N_O    = pins_q.re_n;
    assign WP_N_O             = pins_q.wp_n;
    assign POWER_ON_PROTECT_O = pins_q.protect;
    assign IO_BUS_O           = io_q;
    assign IO_BUS_OE_O        = oe_q;
    assign BUSY_O             = busy_q;
    assign DONE_O             = done_q;
    assign DATA_VALID_O       = buf_out_valid;
    assign DATA_O             = buf_out_data;

    AST_WE_WITH_CE: assert property (@(posedge CLK_I) disable iff (RST_I)
        !WE_N_O |-> !CE_N_O) else $error("write strobe without chip enable");
    AST_NO_RE_DURING_WE: assert property (@(posedge CLK_I) disable iff (RST_I)
        !(!WE_N_O && !READ_STROBE_N_O)) else $error("both strobes low");
    AST_LATCH_EXCL: assert property (@(posedge CLK_I) disable iff (RST_I)
        !(CLE_O && ALE_O)) else $error("both latch enables high");
    sequence s_cmd_start;
        state_q == nand_host_pkg::ST_IDLE ##1 state_q == nand_host_pkg::ST_CMD;
    endsequence
    AST_SETUP_CMD: assert property (@(posedge CLK_I) disable iff (RST_I)
        s_cmd_start |-> CLE_O && IO_BUS_OE_O && IO_BUS_O == 8'h00) else $error("bad setup command");
    AST_CONFIRM_CMD: assert property (@(posedge CLK_I) disable iff (RST_I)
        state_q == nand_host_pkg::ST_CONF |-> CLE_O && IO_BUS_O == 8'h30) else $error("bad confirm");
    AST_COL_HI: assert property (@(posedge CLK_I) disable iff (RST_I)
        ALE_O && acnt_q == 3'h2 |-> IO_BUS_O[7:4] == 4'h0) else $error("column high nibble set");
    AST_WE_LOW_WIDTH: assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(WE_N_O) |-> !WE_N_O [*5]) else $error("write strobe too short");
    AST_DATA_LATCHES_LOW: assert property (@(posedge CLK_I) disable iff (RST_I)
        !READ_STROBE_N_O |-> !CLE_O && !ALE_O && !IO_BUS_OE_O) else $error("latch high in read");
    AST_READ_AFTER_READY: assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(READ_STROBE_N_O) |-> rb_q) else $error("read while busy");
    AST_RE_LOW_WIDTH: assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(READ_STROBE_N_O) |-> !READ_STROBE_N_O [*6]) else $error("read strobe too short");
endmodule : nand_host_ctrl

// file: nand_host_pkg.sv
// Types shared by the NAND host controller
package nand_host_pkg;
    typedef struct packed {
        logic [11:0] col;
        logic [15:0] row;
    } page_addr_s;
    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       re_n;
        logic       wp_n;
        logic       protect;
    } ctrl_pins_s;
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_CMD   = 8'h02,
        ST_ADDR  = 8'h04,
        ST_CONF  = 8'h08,
        ST_WAITB = 8'h10,
        ST_BUSY  = 8'h20,
        ST_READ  = 8'h40,
        ST_DONE  = 8'h80
    } host_state_e;
endpackage : nand_host_pkg

// file: nand_skid_buf.sv
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`include "nand_host_consts.svh"
module nand_skid_buf
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Fill side
    input  wire logic       in_valid_i,
    input  wire logic [7:0] in_data_i,
    output logic            in_ready_o,
    // Drain side
    output logic            out_valid_o,
    output logic [7:0]      out_data_o,
    input  wire logic       out_ready_i
);
    logic [7:0] mem_q [2];
    logic       wr_ptr_q;
    logic       rd_ptr_q;
    logic [1:0] cnt_q;
    logic       out_valid_q;
    logic [7:0] out_data_q;
    wire        push = in_valid_i && (cnt_q != 2'h2);
    wire        pop  = out_ready_i && (cnt_q != 2'h0);
    // Next pointer, count and head byte, so the drain side leaves flops
    wire        rd_ptr_d = rd_ptr_q ^ pop;
    wire  [1:0] cnt_d    = cnt_q + {1'b0, push} - {1'b0, pop};
    wire  [7:0] head_d   = (push && (wr_ptr_q == rd_ptr_d)) ? in_data_i : mem_q[rd_ptr_d];

    assign in_ready_o  = cnt_q != 2'h2;
    assign out_valid_o = out_valid_q;
    assign out_data_o  = out_data_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q    <= 2'h0;
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
            out_valid_q <= 1'b0;
            out_data_q  <= 8'h00;
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_ptr_q] <= in_data_i;
                wr_ptr_q        <= ~wr_ptr_q;
            end
            rd_ptr_q    <= rd_ptr_d;
            cnt_q       <= cnt_d;
            out_valid_q <= cnt_d != 2'h0;
            out_data_q  <= head_d;
        end
    end
endmodule : nand_skid_buf

// file: tb_top.sv
// Self-checking bench for the NAND host controller page read
`timescale 1ns/1ps
module tb_top;
    typedef struct packed
    {
        logic [11:0] col;
        logic [15:0] row;
        logic [11:0] n_bytes;
    } case_s;
    case_s rows [3] = '{'{12'h83D, 16'hA5C3, 12'h003}, '{12'h7FF, 16'h0001, 12'h041},
                        '{12'h000, 16'hFFFF, 12'h840}};
    logic        clk, rst, start, wp_en, protect, busy, done, dvalid, dready, standby;
    logic        ce_n, cle, ale, we_n, re_n, wp_n, pprot, io_oe, rb_low, rb;
    logic [11:0] col_in;
    logic [15:0] row_in;
    logic [7:0]  data, io_out, dev_io, io_wire;
    int          n_mismatch = 0;
    int          checks = 0;
    assign io_wire = io_oe ? io_out : dev_io;
    assign rb = rb_low ? 1'b0 : 1'b1;
    nand_host_ctrl nand_host_ctrl_i
    (
        .CLK_I(clk), .RST_I(rst), .START_I(start), .COL_I(col_in), .ROW_I(row_in),
        .WP_ENABLE_I(wp_en), .PROTECT_I(protect), .BUSY_O(busy), .DONE_O(done),
        .DATA_VALID_O(dvalid), .DATA_O(data), .DATA_READY_I(dready),
        .CE_N_O(ce_n), .CLE_O(cle), .ALE_O(ale), .WE_N_O(we_n), .READ_STROBE_N_O(re_n),
        .WP_N_O(wp_n), .POWER_ON_PROTECT_O(pprot), .IO_BUS_O(io_out), .IO_BUS_OE_O(io_oe),
        .IO_BUS_I(io_wire), .RB_I(rb)
    );
    nand_flash_model nand_flash_model_i
    (
        .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .re_n_i(re_n),
        .wp_n_i(wp_n), .protect_i(pprot), .io_i(io_wire), .io_o(dev_io),
        .rb_low_o(rb_low), .standby_o(standby)
    );
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic fail_hang(input string what);
        n_mismatch++;
        $display("mismatch %s expected done seen timeout", what);
        give_verdict();
    endtask : fail_hang
    function automatic logic [7:0] pat(input logic [11:0] c, input logic [15:0] r);
        return c[7:0] ^ r[7:0] ^ r[15:8] ^ {4'h0, c[11:8]};
    endfunction : pat
    task automatic run_read(input logic [11:0] c, input logic [15:0] r, input logic [11:0] nb);
        int   n;
        int   conf0;
        int   rd0;
        logic got_done;
        n = 0;
        got_done = 1'b0;
        conf0 = nand_flash_model_i.n_conf;
        rd0 = nand_flash_model_i.n_reads;
        col_in = c;
        row_in = r;
        start = 1'b1;
        for (int cyc = 0; cyc < 60000 && !(got_done === 1'b1 && dvalid === 1'b0); cyc++)
        begin
            @(posedge clk);
            #1;
            if (done === 1'b1)
                got_done = 1'b1;
            // Restart while busy and stalls that fill the buffer
            start = (cyc == 200);
            dready = (cyc % 256) >= 40;
            // A byte shown now with ready high is taken at the next edge
            if (dvalid === 1'b1 && dready === 1'b1)
            begin
                check(16'(data), 16'(pat(c + 12'(n), r)), "read byte");
                n++;
            end
        end
        if (got_done !== 1'b1)
            fail_hang("page read");
        check(16'(n), 16'(nb), "byte count");
        check(16'(nand_flash_model_i.n_reads - rd0), 16'(nb), "read strobes");
        check(16'(nand_flash_model_i.n_conf - conf0), 16'h0001, "confirms");
        check(nand_flash_model_i.cmd_hist, 16'h0030, "command pair");
        check({nand_flash_model_i.addr_q[1], nand_flash_model_i.addr_q[0]}, {4'h0, c}, "column");
        check({nand_flash_model_i.addr_q[3], nand_flash_model_i.addr_q[2]}, r, "row");
        repeat (3) @(posedge clk);
        #1;
        check(16'(ce_n), 16'h0001, "chip enable idle");
        check(16'(standby), 16'h0001, "standby");
        check(16'(busy), 16'h0000, "busy");
        check(16'(nand_flash_model_i.n_viol), 16'h0000, "bus violations");
    endtask : run_read
    initial
    begin
        rst = 1'b1;
        {start, wp_en, protect, dready} = 4'h0;
        col_in = 12'h000;
        row_in = 16'h0000;
        repeat (5) @(posedge clk);
        #1;
        check({ce_n, we_n, re_n, cle, ale, io_oe, dvalid}, 16'h0070, "reset pins");
        check(16'(wp_n), 16'h0000, "write protect reset");
        rst = 1'b0;
        wp_en = 1'b1;
        protect = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(16'(wp_n), 16'h0001, "write protect");
        check(16'(pprot), 16'h0001, "protect pin");
        for (int k = 0; k < 3; k++)
            run_read(rows[k].col, rows[k].row, rows[k].n_bytes);
        col_in = 12'h800;
        row_in = 16'h0002;
        start = 1'b1;
        for (int i = 0; i < 20000 && dvalid !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
            start = 1'b0;
        end
        if (dvalid !== 1'b1)
            fail_hang("data before reset");
        rst = 1'b1;
        #1;
        check({ce_n, we_n, re_n, io_oe, dvalid}, 16'h001C, "mid read reset");
        @(posedge clk);
        #1;
        rst = 1'b0;
        run_read(12'h83F, 16'h00FF, 12'h001);
        give_verdict();
    end
endmodule : tb_top
